// [core/tgs_lock_timer.sv]
// tgs_lock_timer: synthesizer lock detect with optional timeout
// assumes: start is a one-cycle pulse, locked is synchronous to clk_i
`timescale 1ns/1ps
`include "tgs_params.svh"
module tgs_lock_timer #(
  parameter int LOCK_NS = `TGS_LOCK_NS
) (
  // clock and reset
  input  logic clk_i,
  input  logic rst_n_i,
  // control
  input  logic start_i,
  input  logic locked_i,
  input  logic unlimited_i,
  // result
  output logic ok_o,
  output logic fail_o,
  output logic ok_evt_o,
  output logic fail_evt_o
);
  localparam int LOCK_CYC = (LOCK_NS * `TGS_CLK_MHZ) / 1000;
  localparam int CNT_W    = $clog2(LOCK_CYC + 1);

  tgs_pkg::tgs_lock_st_t st_q, st_d;
  logic [CNT_W-1:0]      cnt_q, cnt_d;
  logic                  ok_d, fail_d, oke_d, fle_d;

  // next state; a restart drops the previous verdict
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    ok_d   = ok_o;
    fail_d = fail_o;
    oke_d  = 1'b0;
    fle_d  = 1'b0;
    if (start_i) begin
      st_d   = tgs_pkg::TGS_LK_WAIT;
      cnt_d  = '0;
      ok_d   = 1'b0;
      fail_d = 1'b0;
    end else begin
      case (st_q)
        tgs_pkg::TGS_LK_WAIT: begin
          if (locked_i) begin
            st_d  = tgs_pkg::TGS_LK_DONE;
            ok_d  = 1'b1;
            oke_d = 1'b1;
          end else if (!unlimited_i && cnt_q == CNT_W'(LOCK_CYC - 1)) begin
            st_d   = tgs_pkg::TGS_LK_DONE;
            fail_d = 1'b1;
            fle_d  = 1'b1;
          end else if (!unlimited_i) begin
            cnt_d = cnt_q + 1'b1;
          end // unlimited waits here without counting
        end
        default: st_d = st_q;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q       <= tgs_pkg::TGS_LK_IDLE;
      cnt_q      <= '0;
      ok_o       <= 1'b0;
      fail_o     <= 1'b0;
      ok_evt_o   <= 1'b0;
      fail_evt_o <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      ok_o       <= ok_d;
      fail_o     <= fail_d;
      ok_evt_o   <= oke_d;
      fail_evt_o <= fle_d;
    end
  end

  // ----
  // checks
  // ----
  property p_lock_timeout;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_q == tgs_pkg::TGS_LK_WAIT && !start_i && !locked_i && !unlimited_i
     && cnt_q == CNT_W'(LOCK_CYC - 1)) |=> (fail_o && fail_evt_o && !ok_o);
  endproperty
  a_lock_timeout: assert property (p_lock_timeout)
    else $error("lock timeout did not raise failure");

  property p_lock_unlim;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_q == tgs_pkg::TGS_LK_WAIT && unlimited_i && !locked_i && !start_i)
      |=> (st_q == tgs_pkg::TGS_LK_WAIT && !fail_o);
  endproperty
  a_lock_unlim: assert property (p_lock_unlim)
    else $error("unlimited lock wait ended without lock");

  c_lock_fail: cover property (@(posedge clk_i) disable iff (!rst_n_i) $rose(fail_o));
endmodule : tgs_lock_timer

// [core/tgs_params.svh]
// tgs_params.svh: offsets, field positions, reset values, codes, timing
// assumes: included by bare name from core/ design files
`ifndef TGS_PARAMS_SVH
`define TGS_PARAMS_SVH

// ----
// register indices (byte address = index * 4)
// ----
`define TGS_IDX_GEN   6'h0c
`define TGS_IDX_GPO   6'h0d
`define TGS_IDX_POLL  6'h0e
`define TGS_IDX_LSTA  6'h10
`define TGS_IDX_LSTB  6'h30
`define TGS_IDX_ISTS  6'h14
`define TGS_IDX_IMSK  6'h15

// ----
// field positions and writable masks
// ----
`define TGS_GEN_CLK_HI 7
`define TGS_GEN_CLK_LO 5
`define TGS_GEN_LOCKINF 4
`define TGS_GEN_PAGAIN 2
`define TGS_GEN_STBY   1
`define TGS_GEN_XSEL   0
`define TGS_LST_EN     0
`define TGS_LST_CH_LO  1
`define TGS_LST_CH_HI  3
`define TGS_LST_RES    4
`define TGS_MSK_GEN   8'hf7
`define TGS_MSK_GPO   8'h0f
`define TGS_MSK_POLL  8'hff
`define TGS_MSK_LST   8'h1f
`define TGS_MSK_IRQ   8'h07

// ----
// reset values
// ----
`define TGS_RST_GEN   8'h00
`define TGS_RST_GPO   8'h00
`define TGS_RST_POLL  8'hff
`define TGS_RST_LST   8'h00
`define TGS_RST_IRQ   8'h00

// ----
// codes
// ----
`define TGS_CLK_OFF   3'h7
`define TGS_DIV_6     8'h02
`define TGS_DIV_5     8'h04
`define TGS_DIV_4     8'h08
`define TGS_DIV_3     8'h10
`define TGS_DIV_2     8'h28
`define TGS_DIV_1     8'h50
`define TGS_DIV_0     8'ha0
`define TGS_DIV_NONE  8'h00
`define TGS_POLL_OFF  8'hff
`define TGS_GPO_TXEN  4'h1
`define TGS_GPO_LOK   4'h2
`define TGS_GPO_LFAIL 4'h3
`define TGS_GPO_XPD   4'h4
`define TGS_GPO_OVFA  4'h5
`define TGS_GPO_QSF   4'h6
`define TGS_GPO_ENGY  4'h7
`define TGS_GPO_ANY   4'h8
`define TGS_GPO_OVFB  4'h9
`define TGS_GPO_LSTB  4'ha
`define TGS_GPO_LSTA  4'hb
`define TGS_GPO_BUSY  4'hc
`define TGS_IRQ_FAIL  0
`define TGS_IRQ_OK    1
`define TGS_IRQ_POLL  2
`define TGS_RESP_OK   2'h0
`define TGS_RESP_ERR  2'h2

// ----
// timing
// ----
`define TGS_CLK_MHZ   20
`define TGS_LOCK_NS   130000

`endif

// [core/tgs_pkg.sv]
// tgs_pkg: types shared by the configuration block
// assumes: nothing beyond a SystemVerilog compiler
package tgs_pkg;
  // lock detector sequence
  typedef enum logic [1:0] {TGS_LK_IDLE, TGS_LK_WAIT, TGS_LK_DONE} tgs_lock_st_t;
  // register selector from the address decoder
  typedef enum logic [2:0] {
    TGS_R_GEN, TGS_R_GPO, TGS_R_POLL, TGS_R_LSTA, TGS_R_LSTB,
    TGS_R_ISTS, TGS_R_IMSK, TGS_R_NONE
  } tgs_reg_t;
endpackage : tgs_pkg

// [core/tgs_regs.sv]
// tgs_regs: transceiver general options, output pin routing, poll timer
// and listen configuration, reached over AXI4-Lite
// assumes: all status inputs and the 1 Hz tick are synchronous to clk_i
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "tgs_params.svh"
module tgs_regs #(
  parameter int ADDR_W  = 8,
  parameter int LOCK_NS = `TGS_LOCK_NS
) (
  // clock and reset
  input  logic              clk_i,
  input  logic              rst_n_i,
  // axi4-lite write
  input  logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  logic              s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  logic [31:0]       s_axi_wdata_i,
  input  logic [3:0]        s_axi_wstrb_i,
  input  logic              s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  logic              s_axi_bready_i,
  // axi4-lite read
  input  logic [ADDR_W-1:0] s_axi_araddr_i,
  input  logic              s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  logic              s_axi_rready_i,
  // radio status inputs
  input  logic              lock_start_i,
  input  logic              pll_locked_i,
  input  logic              tick_1hz_i,
  input  logic              listen_a_act_i,
  input  logic              listen_b_act_i,
  input  logic              listen_a_ovf_i,
  input  logic              listen_b_ovf_i,
  input  logic              energy_det_i,
  input  logic              qstart_fail_i,
  input  logic              adc_busy_i,
  input  logic              tx_en_i,
  input  logic [2:0]        quiet_chan_i,
  // configuration outputs
  output logic [7:0]        sys_div_o,
  output logic              sys_clk_off_o,
  output logic              xtal_run_o,
  output logic              crystal_frequency_select_o,
  output logic              pa_gain2_o,
  output logic              listen_a_en_o,
  output logic              listen_a_res_100ms_o,
  output logic [2:0]        rx_permit_a_o,
  output logic              listen_b_en_o,
  output logic              listen_b_res_100ms_o,
  output logic [2:0]        rx_permit_b_o,
  // status outputs
  output logic              general_output_pin_o,
  output logic              poll_wake_o,
  output logic              lock_fail_o,
  output logic              lock_ok_o,
  output logic              irq_o
);

  // ----
  // decode helpers
  // ----
  // address to register, used by both the write and the read path
  function automatic tgs_pkg::tgs_reg_t reg_of(input logic [ADDR_W-1:0] a);
    logic [5:0] idx;
    idx = a[7:2];
    reg_of = tgs_pkg::TGS_R_NONE;
    if (a[1:0] == 2'h0) begin
      case (idx)
        `TGS_IDX_GEN:  reg_of = tgs_pkg::TGS_R_GEN;
        `TGS_IDX_GPO:  reg_of = tgs_pkg::TGS_R_GPO;
        `TGS_IDX_POLL: reg_of = tgs_pkg::TGS_R_POLL;
        `TGS_IDX_LSTA: reg_of = tgs_pkg::TGS_R_LSTA;
        `TGS_IDX_LSTB: reg_of = tgs_pkg::TGS_R_LSTB;
        `TGS_IDX_ISTS: reg_of = tgs_pkg::TGS_R_ISTS;
        `TGS_IDX_IMSK: reg_of = tgs_pkg::TGS_R_IMSK;
        default:       reg_of = tgs_pkg::TGS_R_NONE;
      endcase
    end
  endfunction : reg_of

  // clock select code to divide ratio, zero when stopped
  function automatic logic [7:0] div_of(input logic [2:0] c);
    case (c)
      3'h6:    div_of = `TGS_DIV_6;
      3'h5:    div_of = `TGS_DIV_5;
      3'h4:    div_of = `TGS_DIV_4;
      3'h3:    div_of = `TGS_DIV_3;
      3'h2:    div_of = `TGS_DIV_2;
      3'h1:    div_of = `TGS_DIV_1;
      3'h0:    div_of = `TGS_DIV_0;
      default: div_of = `TGS_DIV_NONE;
    endcase
  endfunction : div_of

  // ----
  // register file and bus slave
  // ----
  logic [7:0]        gen_q, gen_d, gpo_q, gpo_d, poll_q, poll_d;
  logic [7:0]        lsta_q, lsta_d, lstb_q, lstb_d, ists_q, ists_d, imsk_q, imsk_d;
  logic              awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic [7:0]        wd_q, wd_d;
  logic              wb0_q, wb0_d;
  logic [1:0]        br_q, br_d, rr_q, rr_d;
  logic [31:0]       rd_q, rd_d;
  logic              wr_go;
  logic [7:0]        ev;
  logic              lk_ok_evt, lk_fail_evt, wake_q;
  tgs_pkg::tgs_reg_t wsel, rsel;

  // handshakes are combinational; one address and one data word are held
  assign s_axi_awready_o = !awh_q;
  assign s_axi_wready_o  = !wh_q;
  assign s_axi_arready_o = !rv_q;
  assign s_axi_bvalid_o  = bv_q;
  assign s_axi_bresp_o   = br_q;
  assign s_axi_rvalid_o  = rv_q;
  assign s_axi_rresp_o   = rr_q;
  assign s_axi_rdata_o   = rd_q;
  assign wsel  = reg_of(awa_q);
  assign rsel  = reg_of(s_axi_araddr_i);
  assign wr_go = awh_q && wh_q && !bv_q;
  // hardware events feeding the sticky status
  assign ev = {5'h00, wake_q, lk_ok_evt, lk_fail_evt};

  // next values of registers and bus state
  always_comb begin
    gen_d  = gen_q;
    gpo_d  = gpo_q;
    poll_d = poll_q;
    lsta_d = lsta_q;
    lstb_d = lstb_q;
    imsk_d = imsk_q;
    ists_d = (ists_q | ev) & `TGS_MSK_IRQ;
    awh_d  = awh_q;
    awa_d  = awa_q;
    wh_d   = wh_q;
    wd_d   = wd_q;
    wb0_d  = wb0_q;
    bv_d   = bv_q;
    br_d   = br_q;
    rv_d   = rv_q;
    rr_d   = rr_q;
    rd_d   = rd_q;
    if (s_axi_awvalid_i && !awh_q) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !wh_q) begin
      wh_d  = 1'b1;
      wd_d  = s_axi_wdata_i[7:0];
      wb0_d = s_axi_wstrb_i[0];
    end
    if (bv_q && s_axi_bready_i) begin
      bv_d = 1'b0;
    end
    // write commits once both halves are held and no response is pending
    if (wr_go) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = (wsel == tgs_pkg::TGS_R_NONE) ? `TGS_RESP_ERR : `TGS_RESP_OK;
      if (wb0_q) begin
        case (wsel)
          tgs_pkg::TGS_R_GEN:  gen_d  = wd_q & `TGS_MSK_GEN;
          tgs_pkg::TGS_R_GPO:  gpo_d  = wd_q & `TGS_MSK_GPO;
          tgs_pkg::TGS_R_POLL: poll_d = wd_q & `TGS_MSK_POLL;
          tgs_pkg::TGS_R_LSTA: lsta_d = wd_q & `TGS_MSK_LST;
          tgs_pkg::TGS_R_LSTB: lstb_d = wd_q & `TGS_MSK_LST;
          tgs_pkg::TGS_R_IMSK: imsk_d = wd_q & `TGS_MSK_IRQ;
          // write one to clear; a same-cycle event still sets
          tgs_pkg::TGS_R_ISTS: ists_d = ((ists_q & ~wd_q) | ev) & `TGS_MSK_IRQ;
          default:             gen_d  = gen_q;
        endcase
      end
    end
    if (rv_q && s_axi_rready_i) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid_i && !rv_q) begin
      rv_d = 1'b1;
      rr_d = (rsel == tgs_pkg::TGS_R_NONE) ? `TGS_RESP_ERR : `TGS_RESP_OK;
      case (rsel)
        tgs_pkg::TGS_R_GEN:  rd_d = {24'h000000, gen_q};
        tgs_pkg::TGS_R_GPO:  rd_d = {24'h000000, gpo_q};
        tgs_pkg::TGS_R_POLL: rd_d = {24'h000000, poll_q};
        tgs_pkg::TGS_R_LSTA: rd_d = {24'h000000, lsta_q};
        tgs_pkg::TGS_R_LSTB: rd_d = {24'h000000, lstb_q};
        tgs_pkg::TGS_R_ISTS: rd_d = {24'h000000, ists_q};
        tgs_pkg::TGS_R_IMSK: rd_d = {24'h000000, imsk_q};
        default:             rd_d = 32'h00000000;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gen_q  <= `TGS_RST_GEN;
      gpo_q  <= `TGS_RST_GPO;
      poll_q <= `TGS_RST_POLL;
      lsta_q <= `TGS_RST_LST;
      lstb_q <= `TGS_RST_LST;
      ists_q <= `TGS_RST_IRQ;
      imsk_q <= `TGS_RST_IRQ;
      awh_q  <= 1'b0;
      awa_q  <= '0;
      wh_q   <= 1'b0;
      wd_q   <= 8'h00;
      wb0_q  <= 1'b0;
      bv_q   <= 1'b0;
      br_q   <= `TGS_RESP_OK;
      rv_q   <= 1'b0;
      rr_q   <= `TGS_RESP_OK;
      rd_q   <= 32'h00000000;
    end else begin
      gen_q  <= gen_d;
      gpo_q  <= gpo_d;
      poll_q <= poll_d;
      lsta_q <= lsta_d;
      lstb_q <= lstb_d;
      ists_q <= ists_d;
      imsk_q <= imsk_d;
      awh_q  <= awh_d;
      awa_q  <= awa_d;
      wh_q   <= wh_d;
      wd_q   <= wd_d;
      wb0_q  <= wb0_d;
      bv_q   <= bv_d;
      br_q   <= br_d;
      rv_q   <= rv_d;
      rr_q   <= rr_d;
      rd_q   <= rd_d;
    end
  end

  assign irq_o = |(ists_q & imsk_q);

  // ----
  // lock detector
  // ----
  tgs_lock_timer #(
    .LOCK_NS (LOCK_NS)
  ) u_lock (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .start_i     (lock_start_i),
    .locked_i    (pll_locked_i),
    .unlimited_i (gen_q[`TGS_GEN_LOCKINF]),
    .ok_o        (lock_ok_o),
    .fail_o      (lock_fail_o),
    .ok_evt_o    (lk_ok_evt),
    .fail_evt_o  (lk_fail_evt)
  );

  // ----
  // noise floor poll timer
  // ----
  logic [7:0] pcnt_q, pcnt_d;
  logic       wake_d, poll_en;

  // runs only in listen mode with the crystal up and polling enabled
  assign poll_en = (poll_q != `TGS_POLL_OFF) && gen_q[`TGS_GEN_STBY]
                   && (lsta_q[`TGS_LST_EN] || lstb_q[`TGS_LST_EN]);

  // next count; an interval of zero wakes on every tick
  always_comb begin
    pcnt_d = pcnt_q;
    wake_d = 1'b0;
    if (!poll_en) begin
      pcnt_d = 8'h00;
    end else if (tick_1hz_i) begin
      if (pcnt_q + 8'h01 >= poll_q) begin
        pcnt_d = 8'h00;
        wake_d = 1'b1;
      end else begin
        pcnt_d = pcnt_q + 8'h01;
      end
    end
  end

  // poll flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pcnt_q <= 8'h00;
      wake_q <= 1'b0;
    end else begin
      pcnt_q <= pcnt_d;
      wake_q <= wake_d;
    end
  end

  assign poll_wake_o = wake_q;

  // ----
  // output routing
  // ----
  logic       pin_d;
  logic [2:0] pa_d, pb_d;

  // pin source select; spare codes fall to the off level
  always_comb begin
    case (gpo_q[3:0])
      `TGS_GPO_TXEN:  pin_d = tx_en_i;
      `TGS_GPO_LOK:   pin_d = lock_ok_o;
      `TGS_GPO_LFAIL: pin_d = lock_fail_o;
      `TGS_GPO_XPD:   pin_d = !gen_q[`TGS_GEN_STBY];
      `TGS_GPO_OVFA:  pin_d = listen_a_ovf_i;
      `TGS_GPO_QSF:   pin_d = qstart_fail_i;
      `TGS_GPO_ENGY:  pin_d = energy_det_i;
      `TGS_GPO_ANY:   pin_d = listen_a_act_i || listen_b_act_i;
      `TGS_GPO_OVFB:  pin_d = listen_b_ovf_i;
      `TGS_GPO_LSTB:  pin_d = listen_b_act_i;
      `TGS_GPO_LSTA:  pin_d = listen_a_act_i;
      `TGS_GPO_BUSY:  pin_d = adc_busy_i;
      default:        pin_d = 1'b0;
    endcase
    pa_d = lsta_q[`TGS_LST_CH_HI:`TGS_LST_CH_LO] & quiet_chan_i;
    pb_d = lstb_q[`TGS_LST_CH_HI:`TGS_LST_CH_LO] & quiet_chan_i;
  end

  // outputs are flopped so the pins never glitch on a register write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      general_output_pin_o       <= 1'b0;
      sys_div_o                  <= `TGS_DIV_0;
      sys_clk_off_o              <= 1'b0;
      xtal_run_o                 <= 1'b0;
      crystal_frequency_select_o <= 1'b0;
      pa_gain2_o                 <= 1'b0;
      listen_a_en_o              <= 1'b0;
      listen_a_res_100ms_o       <= 1'b0;
      rx_permit_a_o              <= 3'h0;
      listen_b_en_o              <= 1'b0;
      listen_b_res_100ms_o       <= 1'b0;
      rx_permit_b_o              <= 3'h0;
    end else begin
      general_output_pin_o       <= pin_d;
      sys_div_o                  <= div_of(gen_q[`TGS_GEN_CLK_HI:`TGS_GEN_CLK_LO]);
      sys_clk_off_o              <= gen_q[`TGS_GEN_CLK_HI:`TGS_GEN_CLK_LO] == `TGS_CLK_OFF;
      xtal_run_o                 <= gen_q[`TGS_GEN_STBY];
      crystal_frequency_select_o <= gen_q[`TGS_GEN_XSEL];
      pa_gain2_o                 <= gen_q[`TGS_GEN_PAGAIN];
      listen_a_en_o              <= lsta_q[`TGS_LST_EN];
      listen_a_res_100ms_o       <= lsta_q[`TGS_LST_RES];
      rx_permit_a_o              <= pa_d;
      listen_b_en_o              <= lstb_q[`TGS_LST_EN];
      listen_b_res_100ms_o       <= lstb_q[`TGS_LST_RES];
      rx_permit_b_o              <= pb_d;
    end
  end

  // ----
  // checks
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_clk_off;
    (gen_q[7:5] == 3'h7) |=> (sys_clk_off_o && sys_div_o == 8'h00);
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("stop code did not stop the clock");

  property p_div160;
    (gen_q[7:5] == 3'h0) |=> (sys_div_o == 8'ha0 && !sys_clk_off_o);
  endproperty
  a_div160: assert property (p_div160)
    else $error("code zero did not divide by 160");

  property p_stby;
    !gen_q[1] |=> (!xtal_run_o && (gpo_q[3:0] != 4'h4 || general_output_pin_o));
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby clear left crystal running");

  property p_pin_a;
    (gpo_q[3:0] == 4'hb) |=> (general_output_pin_o == $past(listen_a_act_i));
  endproperty
  a_pin_a: assert property (p_pin_a)
    else $error("pin does not follow listen A");

  property p_pin_ovfb;
    (gpo_q[3:0] == 4'h9) |=> (general_output_pin_o == $past(listen_b_ovf_i));
  endproperty
  a_pin_ovfb: assert property (p_pin_ovfb)
    else $error("pin does not follow B overflow");

  property p_pin_off;
    (gpo_q[3:0] >= 4'hd || gpo_q[3:0] == 4'h0) |=> !general_output_pin_o;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("spare pin code drove pin");

  property p_poll_off;
    (poll_q == 8'hff) [*2] |-> !poll_wake_o;
  endproperty
  a_poll_off: assert property (p_poll_off)
    else $error("poll woke while disabled");

  property p_poll_tick;
    poll_wake_o |-> ($past(tick_1hz_i) && $past(poll_en));
  endproperty
  a_poll_tick: assert property (p_poll_tick)
    else $error("poll wake without tick");

  property p_chan_gate;
    !lsta_q[1] |=> !rx_permit_a_o[0];
  endproperty
  a_chan_gate: assert property (p_chan_gate)
    else $error("disabled channel permitted");

  property p_lstb_wr;
    (wr_go && wsel == tgs_pkg::TGS_R_LSTB && wb0_q) |=> (lstb_q == ($past(wd_q) & 8'h1f));
  endproperty
  a_lstb_wr: assert property (p_lstb_wr)
    else $error("listen B write not stored");

  property p_w1c;
    (wr_go && wsel == tgs_pkg::TGS_R_ISTS && wb0_q && wd_q[0] && !ev[0]) |=> !ists_q[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("status bit not cleared");

  c_wr:   cover property (wr_go && wsel == tgs_pkg::TGS_R_GEN);
  c_wake: cover property (poll_wake_o);
  c_irq:  cover property ($rose(irq_o));
endmodule : tgs_regs

// [test/tb_tgs_regs.sv]
// tb_tgs_regs: self-checking bench for the configuration register block
// assumes: core/tgs_params.svh on the include path, short lock timeout
`timescale 1ns/1ps
`include "tgs_params.svh"
module tb_tgs_regs;
  // ----
  // stimulus and observed signals
  // ----
  logic       clk_i = 0;
  logic       rst_n_i = 0;
  logic [7:0] awa = 0, ara = 0, wd = 0, rd_d, s = 0;
  logic       awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, st = 0, lk = 0, tk = 0, w;
  logic [2:0] qc = 3'h2;
  logic [1:0] rsp;
  logic [7:0] sys_div_o, dv [8] = '{8'ha0, 8'h50, 8'h28, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00};
  logic [2:0] rx_permit_a_o;
  logic [31:0] rdw;
  logic       awr, wr_o, bv, arr, rv, sys_clk_off_o, xtal_run_o, crystal_frequency_select_o;
  logic       listen_a_en_o, listen_a_res_100ms_o, general_output_pin_o, poll_wake_o;
  logic       lock_fail_o, lock_ok_o, irq_o;
  logic [1:0] br, rr;
  int         err_count = 0, compares = 0, n;
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  tgs_regs #(.LOCK_NS(1000)) tgs_regs_i (
    .clk_i, .rst_n_i, .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i({24'h0, wd}), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_o), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(brd),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdw), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd),
    .lock_start_i(st), .pll_locked_i(lk), .tick_1hz_i(tk), .listen_a_act_i(s[1]),
    .listen_b_act_i(s[2]), .listen_a_ovf_i(s[3]), .listen_b_ovf_i(s[4]),
    .energy_det_i(s[5]), .qstart_fail_i(s[6]), .adc_busy_i(s[7]), .tx_en_i(s[0]),
    .quiet_chan_i(qc), .sys_div_o, .sys_clk_off_o, .xtal_run_o, .crystal_frequency_select_o,
    .pa_gain2_o(), .listen_a_en_o, .listen_a_res_100ms_o, .rx_permit_a_o,
    .listen_b_en_o(), .listen_b_res_100ms_o(), .rx_permit_b_o(), .general_output_pin_o,
    .poll_wake_o, .lock_fail_o, .lock_ok_o, .irq_o);
  // ----
  // checks, bus tasks, verdict
  // ----
  task end_sim;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      err_count++;
    end
  endtask : chk
  // a wait that runs out ends the run as a failure
  task to;
    if (n == 60) begin
      err_count++;
      end_sim;
    end
  endtask : to
  task wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    awv <= 1; wv <= 1; awa <= a; wd <= d; brd <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk_i);
      if (awr) awv <= 0;
      if (wr_o) wv <= 0;
      if (bv) break;
    end
    rsp = br;
    brd <= 0;
    to;
    // flopped outputs launch on the answer edge; look once they settle
    @(negedge clk_i);
  endtask : wrr
  task rdr(input logic [7:0] a);
    @(posedge clk_i);
    arv <= 1; ara <= a; rrd <= 1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk_i);
      if (arr) arv <= 0;
      if (rv) break;
    end
    rd_d = rdw[7:0];
    rsp = rr;
    rrd <= 0;
    to;
    @(negedge clk_i);
  endtask : rdr
  // one tick, then watch a few cycles for the wake pulse
  task tick;
    @(posedge clk_i) tk <= 1;
    @(posedge clk_i) tk <= 0;
    w = 0;
    repeat (3) @(posedge clk_i) w |= poll_wake_o;
  endtask : tick
  // expected pin for selector c; standby is set, lock has succeeded
  function logic px(input logic [3:0] c, input logic [7:0] v);
    case (c)
      4'h1: px = v[0];
      4'h2: px = 1'b1;
      4'h5: px = v[3];
      4'h6: px = v[6];
      4'h7: px = v[5];
      4'h8: px = v[1] | v[2];
      4'h9: px = v[4];
      4'ha: px = v[2];
      4'hb: px = v[1];
      4'hc: px = v[7];
      default: px = 1'b0;
    endcase
  endfunction : px
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1;
    chk(sys_div_o, 8'ha0);
    rdr(8'h38); chk(rd_d, 8'hff);
    rdr(8'h04); chk(rsp, 2'h2);
    wrr(8'h30, 8'hff); rdr(8'h30); chk(rd_d, 8'hf7);
    chk(crystal_frequency_select_o, 1);
    for (int c = 0; c < 8; c++) begin
      wrr(8'h30, {c[2:0], 5'h02}); chk(sys_div_o, dv[c]); chk(sys_clk_off_o, c == 7);
    end
    chk(xtal_run_o, 1);
    wrr(8'h40, 8'hff); rdr(8'h40); chk(rd_d, 8'h1f);
    rdr(8'hc0); chk(rd_d, 8'h00);
    chk({listen_a_en_o, listen_a_res_100ms_o, rx_permit_a_o}, 5'h1a);
    // lock timeout, then the interrupt path
    @(posedge clk_i) st <= 1;
    @(posedge clk_i) st <= 0;
    repeat (25) @(posedge clk_i);
    chk({lock_fail_o, lock_ok_o}, 2'h2);
    wrr(8'h54, 8'h01); @(posedge clk_i); chk(irq_o, 1);
    wrr(8'h50, 8'h01); @(posedge clk_i); chk(irq_o, 0);
    wrr(8'h30, 8'h12);
    @(posedge clk_i) st <= 1;
    @(posedge clk_i) st <= 0;
    repeat (40) @(posedge clk_i);
    chk({lock_fail_o, lock_ok_o}, 2'h0);
    lk <= 1;
    repeat (3) @(posedge clk_i);
    chk(lock_ok_o, 1);
    // every selector code against three source patterns
    for (int c = 0; c < 16; c++) begin
      wrr(8'h34, c[7:0]);
      for (int p = 0; p < 3; p++) begin
        s <= (p == 0) ? 8'h55 : (p == 1) ? 8'haa : 8'h00;
        repeat (3) @(posedge clk_i);
        chk(general_output_pin_o, px(c[3:0], s));
      end
    end
    wrr(8'h38, 8'h02);
    tick; chk(w, 0);
    tick; chk(w, 1);
    wrr(8'h38, 8'hff);
    tick; tick; chk(w, 0);
    // standby clear must stop the crystal and show on the pin
    wrr(8'h34, 8'h04);
    wrr(8'h30, 8'h04);
    repeat (2) @(posedge clk_i);
    chk(xtal_run_o, 0);
    chk(general_output_pin_o, 1);
    end_sim;
  end
endmodule : tb_tgs_regs
